// ==== tws_map.vh ====
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// Register word indices (byte address = index * 4)
`define TWS_REG_CTRL 3'h0
`define TWS_REG_STATUS 3'h1
`define TWS_REG_RHR 3'h2
`define TWS_REG_COUNT 3'h3
`define TWS_REG_TOUT 3'h4
`define TWS_REG_TXD 3'h5

// Control fields
`define TWS_CTRL_EN 0
`define TWS_CTRL_SMBUS_ENABLE_BIT 1
`define TWS_CTRL_ERROR_CHECK_ENABLE_BIT 2
`define TWS_CTRL_CUP 3
`define TWS_CTRL_ACK 4
`define TWS_CTRL_STREN 5
`define TWS_CTRL_SODR 6
`define TWS_CTRL_ADR_LSB 8
`define TWS_CTRL_ADR_MSB 14
`define TWS_CTRL_MASK 32'h00007f7f

// Status fields
`define TWS_ST_RXRDY 0
`define TWS_ST_BTF 1
`define TWS_ST_DIR 2
`define TWS_ST_TCOMP 3
`define TWS_ST_REP 4
`define TWS_ST_PECERR 5
`define TWS_ST_TOUT 6
`define TWS_ST_ORUN 7
`define TWS_ST_MATCH 8
`define TWS_ST_HS 9
`define TWS_ST_NAK 10

// Reset values
`define TWS_CTRL_RST 32'h00000000
`define TWS_COUNT_RST 8'h00
`define TWS_TOUT_RST 16'h0000
`define TWS_TXD_RST 8'hff
`define TWS_CRC_RST 8'h00
`define TWS_SYNC_RST 3'h7

// Protocol constants
`define TWS_BITS_PER_BYTE 4'h8
`define TWS_BIT_ZERO 4'h0
`define TWS_BIT_STEP 4'h1
`define TWS_NB_STEP 8'h01
`define TWS_NB_ZERO 8'h00
`define TWS_CRC_POLY 8'h07
`define TWS_HS_PFX 5'h01
`define TWS_TENBIT_PFX 5'h1e
`define TWS_TOUT_STEP 16'h0001
`define TWS_TOUT_ZERO 16'h0000

`endif

// ==== tws_receive.v ====
// Contract
// - Address match with write bit clears direction flag one cycle after match flag.
// - After address phase, bytes are received repeatedly, byte-done set per byte.
// - Byte counter counts up when count-up selected, otherwise down, per byte.
// - Ordinary received bytes answered ACK or NAK per software ack value.
// - With checking on, byte at counter zero is check byte, auto ACK/NAK.
// - STOP during addressed transfer sets transfer-complete flag.
// - Repeated START after being addressed sets repeated-start flag.
// - Ninth clock: master releases data, slave pulls low to acknowledge.
// - Receive-ready set while holding register full; doubles as DMA request.
// - Without data stretching, ack is driven as receive-ready rises.
// - Stretch-on-data holds clock low, loads holding register, sets byte-done.
// - Stretched ack waits for byte-done clear, drives ack value, frees clock.
// - Count-up from zero adds one per byte moved, showing DMA traffic.
// - SMBus enable selects SMBus operation with seven-bit addresses only.
// - Check enable turns on check handling; generator updates every bit always.
// - Received check byte mismatch sets error-check failure flag.
// - Transmitter sends generated check byte at counter zero; counter includes it.
// - SMBus timeout expiry releases bus lines and sets timeout flag.
// - START in sleep holds clock low until module clock runs, then proceeds.
// - High-speed master code as first byte selects high-speed mode until STOP.
// - Sleep wake: match wakes chip; mismatch drops clock request, back to sleep.
// - Stretching on: new byte with full holding register holds clock until read.
// - Stretching off: new byte with full holding register dropped, overrun set.
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tws_map.vh"

module tws_receive (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire scl_in,
  output wire scl_out,
  output reg scl_oe,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output wire dma_rx_req,
  output wire [7:0] dma_rx_data,
  input wire dma_rx_ack,
  input wire sleep_mode,
  input wire module_clock_ready,
  output reg module_clock_req,
  output reg chip_wake
);

  localparam ST_IDLE = 4'h0;
  localparam ST_WAKE = 4'h1;
  localparam ST_ADDR = 4'h2;
  localparam ST_AACK = 4'h3;
  localparam ST_RX = 4'h4;
  localparam ST_HFULL = 4'h5;
  localparam ST_HACK = 4'h6;
  localparam ST_RACK = 4'h7;
  localparam ST_TX = 4'h8;
  localparam ST_TACK = 4'h9;

  function [31:0] be_mask;
    input [3:0] be;
    begin
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    begin
      wmerge = (old_v & ~be_mask(be)) | (new_v & be_mask(be));
    end
  endfunction

  function [7:0] crc_step;
    input [7:0] c;
    input b;
    begin
      crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `TWS_CRC_POLY : `TWS_CRC_RST);
    end
  endfunction

  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg scl_f;
  reg sda_f;
  reg scl_p;
  reg sda_p;
  reg [31:0] ctrl;
  reg [7:0] byte_counter;
  reg [15:0] tout_limit;
  reg [15:0] tout_cnt;
  reg [7:0] txd;
  reg [7:0] receive_holding_register;
  reg [7:0] shifter;
  reg [7:0] crc;
  reg [7:0] crc_saved;
  reg [3:0] state;
  reg [3:0] bit_cnt;
  reg rx_ready;
  reg byte_done;
  reg direction;
  reg tcomp;
  reg rep;
  reg pec_err;
  reg tout;
  reg orun;
  reg addr_match;
  reg hs_mode;
  reg nak_rx;
  reg addressed;
  reg in_frame;
  reg match_pend;
  reg dir_pend;
  reg pec_q;
  reg pec_ok_q;
  reg [31:0] rd_mux;
  reg [31:0] status_word;

  wire en = ctrl[`TWS_CTRL_EN];
  wire smbus_enable_bit = ctrl[`TWS_CTRL_SMBUS_ENABLE_BIT];
  wire cup = ctrl[`TWS_CTRL_CUP];
  wire ack_nak = ctrl[`TWS_CTRL_ACK];
  wire stren = ctrl[`TWS_CTRL_STREN];
  wire sodr = ctrl[`TWS_CTRL_SODR];
  wire [6:0] own_adr = ctrl[`TWS_CTRL_ADR_MSB:`TWS_CTRL_ADR_LSB];
  wire pec_mode = smbus_enable_bit & ctrl[`TWS_CTRL_ERROR_CHECK_ENABLE_BIT];

  wire scl_rise = scl_f & ~scl_p;
  wire scl_fall = ~scl_f & scl_p;
  wire start_det = scl_f & scl_p & sda_p & ~sda_f;
  wire stop_det = scl_f & scl_p & ~sda_p & sda_f;
  wire byte_end = scl_fall && (bit_cnt == `TWS_BITS_PER_BYTE);
  wire data_bit = scl_rise && (bit_cnt != `TWS_BITS_PER_BYTE);

  wire [7:0] nb_next = cup ? byte_counter + `TWS_NB_STEP : byte_counter - `TWS_NB_STEP;
  wire is_pec = pec_mode && (nb_next == `TWS_NB_ZERO);
  wire pec_ok = (shifter == crc_saved);
  wire ack_drive = is_pec ? pec_ok : ~ack_nak;
  wire accept = ((state == ST_RX && byte_end) || state == ST_HFULL) && !rx_ready;
  wire adr_ok = en && (shifter[7:1] == own_adr) && !(shifter[7:3] == `TWS_TENBIT_PFX);
  wire [7:0] tx_first = (pec_mode && byte_counter == `TWS_NB_ZERO) ? crc : txd;
  wire [7:0] tx_next = (pec_mode && nb_next == `TWS_NB_ZERO) ? crc : txd;

  wire [2:0] widx = avs_address[4:2];
  wire wr_done = avs_write & ~avs_waitrequest;
  wire wr_ctrl = wr_done && widx == `TWS_REG_CTRL;
  wire wr_status = wr_done && widx == `TWS_REG_STATUS;
  wire wr_count = wr_done && widx == `TWS_REG_COUNT;
  wire wr_tout = wr_done && widx == `TWS_REG_TOUT;
  wire wr_txd = wr_done && widx == `TWS_REG_TXD;
  wire [31:0] clr_bits = wr_status ? (avs_writedata & be_mask(avs_byteenable)) : 32'h00000000;
  wire rhr_read = (avs_read && !avs_waitrequest && widx == `TWS_REG_RHR) || dma_rx_ack;
  wire [31:0] count_wr = wmerge({24'h000000, byte_counter}, avs_writedata, avs_byteenable);
  wire [31:0] tout_wr = wmerge({16'h0000, tout_limit}, avs_writedata, avs_byteenable);
  wire [31:0] txd_wr = wmerge({24'h000000, txd}, avs_writedata, avs_byteenable);
  wire tout_hit = (tout_limit != `TWS_TOUT_ZERO) && (tout_cnt == tout_limit);

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign dma_rx_req = rx_ready;
  assign dma_rx_data = receive_holding_register;

  always @* begin
    status_word = 32'h00000000;
    status_word[`TWS_ST_RXRDY] = rx_ready;
    status_word[`TWS_ST_BTF] = byte_done;
    status_word[`TWS_ST_DIR] = direction;
    status_word[`TWS_ST_TCOMP] = tcomp;
    status_word[`TWS_ST_REP] = rep;
    status_word[`TWS_ST_PECERR] = pec_err;
    status_word[`TWS_ST_TOUT] = tout;
    status_word[`TWS_ST_ORUN] = orun;
    status_word[`TWS_ST_MATCH] = addr_match;
    status_word[`TWS_ST_HS] = hs_mode;
    status_word[`TWS_ST_NAK] = nak_rx;
  end

  always @* begin
    case (widx)
      `TWS_REG_CTRL: rd_mux = ctrl;
      `TWS_REG_STATUS: rd_mux = status_word;
      `TWS_REG_RHR: rd_mux = {24'h000000, receive_holding_register};
      `TWS_REG_COUNT: rd_mux = {24'h000000, byte_counter};
      `TWS_REG_TOUT: rd_mux = {16'h0000, tout_limit};
      `TWS_REG_TXD: rd_mux = {24'h000000, txd};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Line synchronisers; a level counts once second and third stage agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= `TWS_SYNC_RST;
      sda_sync <= `TWS_SYNC_RST;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else if (ce) begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  // Bus slave: one wait cycle; read data loads as waitrequest drops, write takes effect at the next edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      ctrl <= `TWS_CTRL_RST;
      tout_limit <= `TWS_TOUT_RST;
      txd <= `TWS_TXD_RST;
    end else if (ce) begin
      if ((avs_read | avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= rd_mux;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (wr_ctrl) begin
        ctrl <= wmerge(ctrl, avs_writedata, avs_byteenable) & `TWS_CTRL_MASK;
      end
      if (wr_tout) begin
        tout_limit <= tout_wr[15:0];
      end
      if (wr_txd) begin
        txd <= txd_wr[7:0];
      end
    end
  end

  // SMBus low-time counter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tout_cnt <= `TWS_TOUT_ZERO;
    end else if (ce) begin
      if (!in_frame || !smbus_enable_bit || scl_f || tout_hit) begin
        tout_cnt <= `TWS_TOUT_ZERO;
      end else begin
        tout_cnt <= tout_cnt + `TWS_TOUT_STEP;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= `TWS_BIT_ZERO;
      shifter <= `TWS_CRC_RST;
      crc <= `TWS_CRC_RST;
      crc_saved <= `TWS_CRC_RST;
      receive_holding_register <= `TWS_CRC_RST;
      byte_counter <= `TWS_COUNT_RST;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rx_ready <= 1'b0;
      byte_done <= 1'b0;
      direction <= 1'b0;
      tcomp <= 1'b0;
      rep <= 1'b0;
      pec_err <= 1'b0;
      tout <= 1'b0;
      orun <= 1'b0;
      addr_match <= 1'b0;
      hs_mode <= 1'b0;
      nak_rx <= 1'b0;
      addressed <= 1'b0;
      in_frame <= 1'b0;
      match_pend <= 1'b0;
      dir_pend <= 1'b0;
      pec_q <= 1'b0;
      pec_ok_q <= 1'b0;
      module_clock_req <= 1'b0;
      chip_wake <= 1'b0;
    end else if (ce) begin
      // Software clears first; hardware sets below win in the same cycle
      if (clr_bits[`TWS_ST_BTF]) byte_done <= 1'b0;
      if (clr_bits[`TWS_ST_TCOMP]) tcomp <= 1'b0;
      if (clr_bits[`TWS_ST_REP]) rep <= 1'b0;
      if (clr_bits[`TWS_ST_PECERR]) pec_err <= 1'b0;
      if (clr_bits[`TWS_ST_TOUT]) tout <= 1'b0;
      if (clr_bits[`TWS_ST_ORUN]) orun <= 1'b0;
      if (clr_bits[`TWS_ST_MATCH]) addr_match <= 1'b0;
      if (clr_bits[`TWS_ST_NAK]) nak_rx <= 1'b0;
      if (rhr_read) rx_ready <= 1'b0;
      if (wr_count) byte_counter <= count_wr[7:0];
      if (!sleep_mode) begin
        module_clock_req <= 1'b0;
        chip_wake <= 1'b0;
      end
      match_pend <= 1'b0;
      if (match_pend) begin
        direction <= dir_pend;
      end
      if (data_bit && (state == ST_ADDR || state == ST_RX || state == ST_TX)) begin
        crc <= crc_step(crc, sda_f);
      end
      if (accept) begin
        receive_holding_register <= shifter;
        rx_ready <= 1'b1;
        byte_done <= 1'b1;
        if (!wr_count) byte_counter <= nb_next;
        if (is_pec && !pec_ok) pec_err <= 1'b1;
        pec_q <= is_pec;
        pec_ok_q <= pec_ok;
        if (sodr) begin
          scl_oe <= 1'b1;
          state <= ST_HACK;
        end else begin
          sda_oe <= ack_drive;
          state <= ST_RACK;
        end
      end
      case (state)
        ST_IDLE: begin
        end
        ST_WAKE: begin
          if (module_clock_ready) begin
            scl_oe <= 1'b0;
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (data_bit) begin
            shifter <= {shifter[6:0], sda_f};
            bit_cnt <= bit_cnt + `TWS_BIT_STEP;
          end else if (byte_end) begin
            if (!hs_mode && shifter[7:3] == `TWS_HS_PFX) begin
              hs_mode <= 1'b1;
              state <= ST_IDLE;
            end else if (adr_ok) begin
              addr_match <= 1'b1;
              match_pend <= 1'b1;
              dir_pend <= shifter[0];
              addressed <= 1'b1;
              sda_oe <= 1'b1;
              if (sleep_mode) chip_wake <= 1'b1;
              state <= ST_AACK;
            end else begin
              if (sleep_mode) module_clock_req <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_cnt <= `TWS_BIT_ZERO;
            if (dir_pend) begin
              shifter <= tx_first;
              sda_oe <= ~tx_first[7];
              state <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              state <= ST_RX;
            end
          end
        end
        ST_RX: begin
          if (data_bit) begin
            if (bit_cnt == `TWS_BIT_ZERO) crc_saved <= crc;
            shifter <= {shifter[6:0], sda_f};
            bit_cnt <= bit_cnt + `TWS_BIT_STEP;
          end else if (byte_end && rx_ready) begin
            if (stren) begin
              scl_oe <= 1'b1;
              state <= ST_HFULL;
            end else begin
              orun <= 1'b1;
              sda_oe <= ~ack_nak;
              state <= ST_RACK;
            end
          end
        end
        ST_HFULL: begin
        end
        ST_HACK: begin
          if (!byte_done) begin
            sda_oe <= pec_q ? pec_ok_q : ~ack_nak;
            state <= ST_RACK;
          end
        end
        ST_RACK: begin
          // Clock freed a cycle after the ack level, for data setup
          scl_oe <= 1'b0;
          if (scl_fall) begin
            sda_oe <= 1'b0;
            bit_cnt <= `TWS_BIT_ZERO;
            state <= ST_RX;
          end
        end
        ST_TX: begin
          if (data_bit) begin
            bit_cnt <= bit_cnt + `TWS_BIT_STEP;
          end else if (byte_end) begin
            sda_oe <= 1'b0;
            state <= ST_TACK;
          end else if (scl_fall) begin
            shifter <= {shifter[6:0], 1'b0};
            sda_oe <= ~shifter[6];
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            nak_rx <= sda_f;
          end else if (scl_fall) begin
            byte_done <= 1'b1;
            if (!wr_count) byte_counter <= nb_next;
            bit_cnt <= `TWS_BIT_ZERO;
            if (nak_rx) begin
              state <= ST_IDLE;
            end else begin
              shifter <= tx_next;
              sda_oe <= ~tx_next[7];
              state <= ST_TX;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (start_det) begin
        if (addressed) rep <= 1'b1;
        if (!in_frame) crc <= `TWS_CRC_RST;
        in_frame <= 1'b1;
        addressed <= 1'b0;
        sda_oe <= 1'b0;
        bit_cnt <= `TWS_BIT_ZERO;
        if (sleep_mode && !module_clock_ready) begin
          module_clock_req <= 1'b1;
          scl_oe <= 1'b1;
          state <= ST_WAKE;
        end else begin
          if (sleep_mode) module_clock_req <= 1'b1;
          scl_oe <= 1'b0;
          state <= ST_ADDR;
        end
      end else if (stop_det) begin
        if (addressed) tcomp <= 1'b1;
        addressed <= 1'b0;
        in_frame <= 1'b0;
        hs_mode <= 1'b0;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
        state <= ST_IDLE;
      end
      if (tout_hit) begin
        tout <= 1'b1;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
        addressed <= 1'b0;
        in_frame <= 1'b0;
        state <= ST_IDLE;
      end
    end
  end

endmodule // tws_receive

`default_nettype wire

// ==== tws_rx_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module tws_rx_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic dma_rx_req,
  input wire logic dma_rx_ack,
  input wire logic sleep_mode,
  input wire logic module_clock_ready,
  input wire logic module_clock_req,
  input wire logic chip_wake
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_bus_answer: assert property (ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_wait_once: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("open drain output high");
  a_ack_low_phase: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  a_stretch_low: assert property ($rose(scl_oe) && !sleep_mode |-> !scl_in)
    else $error("stretch began while clock high");
  a_dma_clear: assert property (ce && dma_rx_ack |=> !dma_rx_req)
    else $error("receive request not cleared");
  a_ready_low: assert property ($rose(dma_rx_req) |-> !scl_in)
    else $error("byte ready while clock high");
  a_wake_hold: assert property (sleep_mode && module_clock_req && !module_clock_ready |=> scl_oe)
    else $error("clock not held during wake");
  a_wake_drop: assert property ($fell(sleep_mode) |=> !chip_wake)
    else $error("wake flag kept after sleep");
  a_wake_cause: assert property ($rose(chip_wake) |-> sleep_mode && !scl_in)
    else $error("wake outside sleep address phase");
endmodule // tws_rx_props

bind tws_receive tws_rx_props u_props (.clk, .rst_n, .ce, .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe,
  .avs_read, .avs_write, .avs_waitrequest, .dma_rx_req, .dma_rx_ack, .sleep_mode, .module_clock_ready,
  .module_clock_req, .chip_wake);
`default_nettype wire

// ==== tws_i2c_mst.sv ====
`timescale 1ns/1ps
`default_nettype none
module tws_i2c_mst #(
  parameter int PH = 50
) (
  input wire logic clk,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic half();
    repeat (PH) @(posedge clk);
  endtask

  // Raise clock and wait out any stretching
  task automatic hi();
    int n;
    n = 0;
    scl_drv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (scl_line !== 1'b1 && n < 20000);
  endtask

  task automatic bit_io(input logic b, output logic r);
    half();
    sda_drv <= b;
    half();
    hi();
    half();
    r = sda_line;
    scl_drv <= 1'b0;
  endtask

  task automatic start_cond();
    half();
    sda_drv <= 1'b1;
    half();
    hi();
    half();
    sda_drv <= 1'b0;
    half();
    scl_drv <= 1'b0;
  endtask

  task automatic stop_cond();
    half();
    sda_drv <= 1'b0;
    half();
    hi();
    half();
    sda_drv <= 1'b1;
    half();
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack_n);
  endtask
endmodule // tws_i2c_mst
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic dma_rx_ack = 1'b0;
  logic sleep_mode = 1'b0;
  logic module_clock_ready = 1'b1;
  logic [31:0] avs_readdata;
  logic [7:0] dma_rx_data;
  logic avs_waitrequest, dma_rx_req, module_clock_req, chip_wake;
  logic scl_oe, sda_oe, scl_drv, sda_drv;
  wire scl_line = scl_drv & ~scl_oe;
  wire sda_line = sda_drv & ~sda_oe;
  int mismatches = 0;
  int check_count = 0;

  always #4 clk = ~clk;

  tws_receive u_dut (.clk, .rst_n, .ce(1'b1), .scl_in(scl_line), .scl_out(), .scl_oe,
    .sda_in(sda_line), .sda_out(), .sda_oe, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .dma_rx_req, .dma_rx_data, .dma_rx_ack,
    .sleep_mode, .module_clock_ready, .module_clock_req, .chip_wake);

  tws_i2c_mst u_mst (.clk, .scl_line, .sda_line, .scl_drv, .sda_drv);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    chk("waitrequest", 32'h0, 32'(avs_waitrequest));
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, e, r & m);
  endtask

  task automatic tx(input logic [7:0] d, input logic e, input string nm);
    logic a;
    u_mst.write_byte(d, a);
    chk(nm, 32'(e), 32'(a));
  endtask

  task automatic dack();
    @(posedge clk);
    dma_rx_ack <= 1'b1;
    @(posedge clk);
    dma_rx_ack <= 1'b0;
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction

  task automatic wake(input logic [7:0] a, input logic e);
    module_clock_ready <= 1'b0;
    fork
      begin
        u_mst.start_cond();
        tx(a, e, "wake addr");
      end
      begin
        repeat (300) @(posedge clk);
        chk("wake hold", 32'h1, 32'(scl_oe & module_clock_req));
        module_clock_ready <= 1'b1;
      end
    join
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("ERROR watchdog expected done seen hang");
    end_of_test();
  end

  initial begin
    logic [31:0] v;
    logic [7:0] p;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd("ctrl rst", 5'h00, 32'hffffffff, 32'h0);
    rd("status rst", 5'h04, 32'hffffffff, 32'h0);
    wr(5'h18, 32'hff);
    rd("unmapped", 5'h18, 32'hffffffff, 32'h0);
    // Plain receive, counting up
    wr(5'h00, 32'h2a09);
    wr(5'h0c, 32'h0);
    u_mst.start_cond();
    tx(8'h54, 1'b0, "addr ack");
    rd("dir", 5'h04, 32'h104, 32'h100);
    tx(8'ha5, 1'b0, "data ack");
    chk("dma", 32'h1a5, {23'h0, dma_rx_req, dma_rx_data});
    dack();
    rd("count up", 5'h0c, 32'hff, 32'h1);
    wr(5'h00, 32'h2a19);
    tx(8'h3c, 1'b1, "data nak");
    rd("rhr", 5'h08, 32'hff, 32'h3c);
    rd("btf", 5'h04, 32'h3, 32'h2);
    u_mst.start_cond();
    rd("rep", 5'h04, 32'h18, 32'h10);
    tx(8'h54, 1'b0, "sr addr");
    u_mst.stop_cond();
    rd("tcomp", 5'h04, 32'h8, 32'h8);
    wr(5'h04, 32'h7fe);
    // Checked transfers: good then corrupted check byte
    wr(5'h00, 32'h2a07);
    for (int k = 0; k < 2; k++) begin
      wr(5'h0c, 32'h2);
      u_mst.start_cond();
      tx(8'h54, 1'b0, "pec addr");
      tx(8'h12, 1'b0, "pec data");
      dack();
      rd("count dn", 5'h0c, 32'hff, 32'h1);
      p = crc8(crc8(8'h00, 8'h54), 8'h12) ^ 8'(k);
      tx(p, k[0], "pec ack");
      dack();
      rd("pec err", 5'h04, 32'h20, 32'(k) << 5);
      u_mst.stop_cond();
    end
    // Generator runs while checking is off
    wr(5'h00, 32'h2a03);
    u_mst.start_cond();
    tx(8'h54, 1'b0, "gen addr");
    tx(8'h12, 1'b0, "gen data");
    dack();
    wr(5'h00, 32'h2a07);
    wr(5'h0c, 32'h1);
    tx(crc8(crc8(8'h00, 8'h54), 8'h12), 1'b0, "gen pec");
    dack();
    u_mst.stop_cond();
    // Holding register full, no stretching, then stretching
    wr(5'h00, 32'h2a01);
    u_mst.start_cond();
    tx(8'h54, 1'b0, "o addr");
    tx(8'h61, 1'b0, "o first");
    tx(8'h62, 1'b0, "o second");
    chk("kept", 32'h61, 32'(dma_rx_data));
    rd("orun", 5'h04, 32'h80, 32'h80);
    wr(5'h00, 32'h2a21);
    fork
      tx(8'h63, 1'b0, "stretch");
      begin
        repeat (1500) @(posedge clk);
        chk("stretch hold", 32'h1, 32'(scl_oe));
        rd("rhr old", 5'h08, 32'hff, 32'h61);
      end
    join
    rd("rhr new", 5'h08, 32'hff, 32'h63);
    u_mst.stop_cond();
    // Interactive acknowledge
    wr(5'h00, 32'h2a41);
    u_mst.start_cond();
    tx(8'h54, 1'b0, "s addr");
    wr(5'h04, 32'h7fe);
    fork
      tx(8'h70, 1'b1, "sodr nak");
      begin
        v = 32'h0;
        for (int i = 0; i < 1000 && v[1] !== 1'b1; i++) bus(1'b0, 5'h04, 32'h0, v);
        chk("sodr", 32'h170, {23'h0, scl_oe, dma_rx_data});
        wr(5'h00, 32'h2a51);
        wr(5'h04, 32'h2);
      end
    join
    dack();
    u_mst.stop_cond();
    // Timeout while clock held low
    wr(5'h00, 32'h2a43);
    wr(5'h10, 32'hc8);
    wr(5'h04, 32'h7fe);
    u_mst.start_cond();
    tx(8'h54, 1'b0, "t addr");
    tx(8'h33, 1'b1, "t data");
    repeat (400) @(posedge clk);
    rd("tout", 5'h04, 32'h40, 32'h40);
    chk("released", 32'h0, 32'({scl_oe, sda_oe}));
    u_mst.stop_cond();
    wr(5'h10, 32'h0);
    // Master code and ten-bit prefix
    u_mst.start_cond();
    tx(8'h08, 1'b1, "mcode");
    rd("hs", 5'h04, 32'h200, 32'h200);
    wr(5'h00, 32'h7803);
    u_mst.start_cond();
    tx(8'hf0, 1'b1, "ten bit");
    u_mst.stop_cond();
    rd("hs off", 5'h04, 32'h200, 32'h0);
    wr(5'h00, 32'h2a03);
    // Wake from sleep: match, then mismatch
    sleep_mode <= 1'b1;
    wake(8'h54, 1'b0);
    chk("wake", 32'h1, 32'(chip_wake));
    u_mst.stop_cond();
    sleep_mode <= 1'b0;
    repeat (2) @(posedge clk);
    sleep_mode <= 1'b1;
    wake(8'h22, 1'b1);
    chk("clk drop", 32'h0, 32'(module_clock_req));
    u_mst.stop_cond();
    sleep_mode <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake clr", 32'h0, 32'(chip_wake));
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
